/* File: pkg/mcrb_pkg.sv */
package mcrb_pkg;

	// ----------------------------------------------------------------
	// Register byte addresses
	// ----------------------------------------------------------------
	localparam logic [8:0] ADDR_STATUS        = 9'h001;
	localparam logic [8:0] ADDR_CAL_CONTROL   = 9'h002;
	localparam logic [8:0] ADDR_RAW_CUR_RMS   = 9'h003;
	localparam logic [8:0] ADDR_CUR_RMS       = 9'h005;
	localparam logic [8:0] ADDR_RAW_VOLT_RMS  = 9'h007;
	localparam logic [8:0] ADDR_VOLT_RMS      = 9'h009;
	localparam logic [8:0] ADDR_LINE_FREQ     = 9'h00b;
	localparam logic [8:0] ADDR_ACT_POWER     = 9'h00d;
	localparam logic [8:0] ADDR_REACT_POWER   = 9'h011;
	localparam logic [8:0] ADDR_APP_POWER     = 9'h015;
	localparam logic [8:0] ADDR_COS_PHI       = 9'h019;
	localparam logic [8:0] ADDR_PHASE_USE     = 9'h01b;
	localparam logic [8:0] ADDR_CUR_SCALE     = 9'h01c;
	localparam logic [8:0] ADDR_ACT_SCALE     = 9'h01e;
	localparam logic [8:0] ADDR_REACT_SCALE   = 9'h020;
	localparam logic [8:0] ADDR_PULSE_SCALE   = 9'h022;

	// ----------------------------------------------------------------
	// Calibration control and status field positions
	// ----------------------------------------------------------------
	localparam int CTL_CAL_MODE_BIT    = 0;
	localparam int CTL_FORCE_BIT       = 2;
	localparam int CTL_SEL_LOW_BIT     = 3;
	localparam int CTL_FIRST_CYCLE_BIT = 4;
	localparam int STATUS_REGION_BIT   = 0;

	// ----------------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------------
	localparam logic       CTL_RESET_BIT     = 1'b0;
	localparam logic       REGION_HIGH_RESET = 1'b0;
	localparam logic [7:0] BYTE_ZERO         = 8'h00;
	localparam logic [15:0] WORD_ZERO        = 16'h0000;

endpackage

/* File: src/mcrb_register_bank.sv */
`timescale 1ns/1ps
// Function
// - control bits 7-5 and 1 read zero
// - bit4 flags first line cycle after region change while bit0 auto-calibration is on
// - bit3 selects region, 1 low, 0 high
// - bit2 forces region from bit3, else automatic
// - bit0 write one enables auto-calibration
// - raw current RMS readable, 16 bits
// - calibrated current RMS readable, region scaled
// - raw voltage RMS readable, 16 bits
// - calibrated voltage RMS readable, one decimal
// - line frequency readable, three decimals
// - active power readable, 32 bits
// - reactive power readable, 32 bits
// - apparent power readable, 32 bits
// - power factor readable as times 65535
// - phase delay in use follows region
// - current gain in use follows region
// - active power gain in use follows region
// - reactive power gain in use follows region
// - pulse gain in use follows region
// - status bit0 shows region, 1 high
module mcrb_register_bank (
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        rst,
	// Byte register port
	input  wire logic [8:0]  reg_addr,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	input  wire logic [7:0]  reg_wdata,
	output logic      [7:0]  reg_rdata,
	output logic             reg_rvalid,
	// Metering engine timing and automatic region choice
	input  wire logic        line_cycle_end,
	input  wire logic        auto_region_high,
	// Measurement results
	input  wire logic [15:0] raw_current_rms,
	input  wire logic [15:0] current_rms,
	input  wire logic [15:0] raw_voltage_rms,
	input  wire logic [15:0] voltage_rms,
	input  wire logic [15:0] line_frequency,
	input  wire logic [31:0] active_power,
	input  wire logic [31:0] reactive_power,
	input  wire logic [31:0] apparent_power,
	input  wire logic [15:0] load_cos_phi,
	// Low and high region calibration sets
	input  wire logic [7:0]  phase_delay_low_set,
	input  wire logic [7:0]  phase_delay_high_set,
	input  wire logic [15:0] current_scale_low_set,
	input  wire logic [15:0] current_scale_high_set,
	input  wire logic [15:0] active_scale_low_set,
	input  wire logic [15:0] active_scale_high_set,
	input  wire logic [15:0] reactive_scale_low_set,
	input  wire logic [15:0] reactive_scale_high_set,
	input  wire logic [15:0] active_pulse_scale_low_set,
	input  wire logic [15:0] active_pulse_scale_high_set,
	// Region and calibration state
	output logic             region_high,
	output logic             cal_mode_on,
	output logic             force_region,
	output logic             first_cycle_after_region_change,
	// Working copies for the metering engine
	output logic      [7:0]  phase_delay_in_use,
	output logic      [15:0] current_scale_in_use,
	output logic      [15:0] active_scale_in_use,
	output logic      [15:0] reactive_scale_in_use,
	output logic      [15:0] active_pulse_scale_in_use
);

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------

	// Picks the high or low region copy of a 16-bit calibration word
	function automatic logic [15:0] region_word(input logic high, input logic [15:0] high_word,
		input logic [15:0] low_word);
		logic [15:0] res;
		res = low_word;
		if (high) begin
			res = high_word;
		end
		return res;
	endfunction

	// Picks the high or low region copy of an 8-bit calibration byte
	function automatic logic [7:0] region_byte(input logic high, input logic [7:0] high_byte,
		input logic [7:0] low_byte);
		logic [7:0] res;
		res = low_byte;
		if (high) begin
			res = high_byte;
		end
		return res;
	endfunction

	// ----------------------------------------------------------------
	// Calibration control
	// ----------------------------------------------------------------
	logic sel_low;
	logic next_region_high;
	logic ctl_write;

	// Writes land only at the control address; all other addresses are read-only
	assign ctl_write = reg_wr && (reg_addr == mcrb_pkg::ADDR_CAL_CONTROL);

	// Auto-calibration enable
	always_ff @(posedge clk) begin
		if (rst) begin
			cal_mode_on <= mcrb_pkg::CTL_RESET_BIT;
		end else if (ctl_write) begin
			cal_mode_on <= reg_wdata[mcrb_pkg::CTL_CAL_MODE_BIT];
		end
	end

	// Bypass of the automatic region choice
	always_ff @(posedge clk) begin
		if (rst) begin
			force_region <= mcrb_pkg::CTL_RESET_BIT;
		end else if (ctl_write) begin
			force_region <= reg_wdata[mcrb_pkg::CTL_FORCE_BIT];
		end
	end

	// Region requested by the calibration device, 1 for low
	always_ff @(posedge clk) begin
		if (rst) begin
			sel_low <= mcrb_pkg::CTL_RESET_BIT;
		end else if (ctl_write) begin
			sel_low <= reg_wdata[mcrb_pkg::CTL_SEL_LOW_BIT];
		end
	end

	// Region chosen for the coming line cycle
	always_comb begin
		if (force_region) begin
			next_region_high = ~sel_low;
		end else begin
			next_region_high = auto_region_high;
		end
	end

	// Region switches only at a line cycle boundary
	always_ff @(posedge clk) begin
		if (rst) begin
			region_high <= mcrb_pkg::REGION_HIGH_RESET;
		end else if (line_cycle_end) begin
			region_high <= next_region_high;
		end
	end

	// Flag set for the one line cycle following a calibration region change
	always_ff @(posedge clk) begin
		if (rst) begin
			first_cycle_after_region_change <= mcrb_pkg::CTL_RESET_BIT;
		end else if (line_cycle_end) begin
			first_cycle_after_region_change <= cal_mode_on && (next_region_high != region_high);
		end
	end

	// ----------------------------------------------------------------
	// Working copies
	// ----------------------------------------------------------------

	// Each copy reloads every clock from the active set, so a region change
	// lands one clock later and well before the next line cycle computation

	// Phase delay copy
	always_ff @(posedge clk) begin
		if (rst) begin
			phase_delay_in_use <= mcrb_pkg::BYTE_ZERO;
		end else begin
			phase_delay_in_use <= region_byte(region_high, phase_delay_high_set, phase_delay_low_set);
		end
	end

	// Current gain copy
	always_ff @(posedge clk) begin
		if (rst) begin
			current_scale_in_use <= mcrb_pkg::WORD_ZERO;
		end else begin
			current_scale_in_use <= region_word(region_high, current_scale_high_set, current_scale_low_set);
		end
	end

	// Active power gain copy
	always_ff @(posedge clk) begin
		if (rst) begin
			active_scale_in_use <= mcrb_pkg::WORD_ZERO;
		end else begin
			active_scale_in_use <= region_word(region_high, active_scale_high_set, active_scale_low_set);
		end
	end

	// Reactive power gain copy
	always_ff @(posedge clk) begin
		if (rst) begin
			reactive_scale_in_use <= mcrb_pkg::WORD_ZERO;
		end else begin
			reactive_scale_in_use <= region_word(region_high, reactive_scale_high_set, reactive_scale_low_set);
		end
	end

	// Active energy pulse gain copy
	always_ff @(posedge clk) begin
		if (rst) begin
			active_pulse_scale_in_use <= mcrb_pkg::WORD_ZERO;
		end else begin
			active_pulse_scale_in_use <= region_word(region_high, active_pulse_scale_high_set,
				active_pulse_scale_low_set);
		end
	end

	// ----------------------------------------------------------------
	// Read path
	// ----------------------------------------------------------------
	logic [7:0] ctl_byte;
	logic [7:0] status_byte;
	logic [7:0] next_rdata;

	// Unimplemented control and status bits are tied to zero
	always_comb begin
		ctl_byte = mcrb_pkg::BYTE_ZERO;
		ctl_byte[mcrb_pkg::CTL_CAL_MODE_BIT]    = cal_mode_on;
		ctl_byte[mcrb_pkg::CTL_FORCE_BIT]       = force_region;
		ctl_byte[mcrb_pkg::CTL_SEL_LOW_BIT]     = sel_low;
		ctl_byte[mcrb_pkg::CTL_FIRST_CYCLE_BIT] = first_cycle_after_region_change;
		status_byte = mcrb_pkg::BYTE_ZERO;
		status_byte[mcrb_pkg::STATUS_REGION_BIT] = region_high;
	end

	// Byte mux; words are little-endian, low byte at the base address.
	// No snapshot is taken, so a word may move between its byte reads.
	always_comb begin
		next_rdata = mcrb_pkg::BYTE_ZERO;
		case (reg_addr)
			// Status and control
			mcrb_pkg::ADDR_STATUS: begin
				next_rdata = status_byte;
			end
			mcrb_pkg::ADDR_CAL_CONTROL: begin
				next_rdata = ctl_byte;
			end
			// Raw current RMS
			mcrb_pkg::ADDR_RAW_CUR_RMS: begin
				next_rdata = raw_current_rms[7:0];
			end
			mcrb_pkg::ADDR_RAW_CUR_RMS + 9'd1: begin
				next_rdata = raw_current_rms[15:8];
			end
			// Calibrated current RMS
			mcrb_pkg::ADDR_CUR_RMS: begin
				next_rdata = current_rms[7:0];
			end
			mcrb_pkg::ADDR_CUR_RMS + 9'd1: begin
				next_rdata = current_rms[15:8];
			end
			// Raw voltage RMS
			mcrb_pkg::ADDR_RAW_VOLT_RMS: begin
				next_rdata = raw_voltage_rms[7:0];
			end
			mcrb_pkg::ADDR_RAW_VOLT_RMS + 9'd1: begin
				next_rdata = raw_voltage_rms[15:8];
			end
			// Calibrated voltage RMS
			mcrb_pkg::ADDR_VOLT_RMS: begin
				next_rdata = voltage_rms[7:0];
			end
			mcrb_pkg::ADDR_VOLT_RMS + 9'd1: begin
				next_rdata = voltage_rms[15:8];
			end
			// Line frequency
			mcrb_pkg::ADDR_LINE_FREQ: begin
				next_rdata = line_frequency[7:0];
			end
			mcrb_pkg::ADDR_LINE_FREQ + 9'd1: begin
				next_rdata = line_frequency[15:8];
			end
			// Active power
			mcrb_pkg::ADDR_ACT_POWER: begin
				next_rdata = active_power[7:0];
			end
			mcrb_pkg::ADDR_ACT_POWER + 9'd1: begin
				next_rdata = active_power[15:8];
			end
			mcrb_pkg::ADDR_ACT_POWER + 9'd2: begin
				next_rdata = active_power[23:16];
			end
			mcrb_pkg::ADDR_ACT_POWER + 9'd3: begin
				next_rdata = active_power[31:24];
			end
			// Reactive power
			mcrb_pkg::ADDR_REACT_POWER: begin
				next_rdata = reactive_power[7:0];
			end
			mcrb_pkg::ADDR_REACT_POWER + 9'd1: begin
				next_rdata = reactive_power[15:8];
			end
			mcrb_pkg::ADDR_REACT_POWER + 9'd2: begin
				next_rdata = reactive_power[23:16];
			end
			mcrb_pkg::ADDR_REACT_POWER + 9'd3: begin
				next_rdata = reactive_power[31:24];
			end
			// Apparent power
			mcrb_pkg::ADDR_APP_POWER: begin
				next_rdata = apparent_power[7:0];
			end
			mcrb_pkg::ADDR_APP_POWER + 9'd1: begin
				next_rdata = apparent_power[15:8];
			end
			mcrb_pkg::ADDR_APP_POWER + 9'd2: begin
				next_rdata = apparent_power[23:16];
			end
			mcrb_pkg::ADDR_APP_POWER + 9'd3: begin
				next_rdata = apparent_power[31:24];
			end
			// Power factor
			mcrb_pkg::ADDR_COS_PHI: begin
				next_rdata = load_cos_phi[7:0];
			end
			mcrb_pkg::ADDR_COS_PHI + 9'd1: begin
				next_rdata = load_cos_phi[15:8];
			end
			// Phase delay in use
			mcrb_pkg::ADDR_PHASE_USE: begin
				next_rdata = phase_delay_in_use;
			end
			// Current gain in use
			mcrb_pkg::ADDR_CUR_SCALE: begin
				next_rdata = current_scale_in_use[7:0];
			end
			mcrb_pkg::ADDR_CUR_SCALE + 9'd1: begin
				next_rdata = current_scale_in_use[15:8];
			end
			// Active power gain in use
			mcrb_pkg::ADDR_ACT_SCALE: begin
				next_rdata = active_scale_in_use[7:0];
			end
			mcrb_pkg::ADDR_ACT_SCALE + 9'd1: begin
				next_rdata = active_scale_in_use[15:8];
			end
			// Reactive power gain in use
			mcrb_pkg::ADDR_REACT_SCALE: begin
				next_rdata = reactive_scale_in_use[7:0];
			end
			mcrb_pkg::ADDR_REACT_SCALE + 9'd1: begin
				next_rdata = reactive_scale_in_use[15:8];
			end
			// Active energy pulse gain in use
			mcrb_pkg::ADDR_PULSE_SCALE: begin
				next_rdata = active_pulse_scale_in_use[7:0];
			end
			mcrb_pkg::ADDR_PULSE_SCALE + 9'd1: begin
				next_rdata = active_pulse_scale_in_use[15:8];
			end
			// Unmapped addresses read as zero
			default: begin
				next_rdata = mcrb_pkg::BYTE_ZERO;
			end
		endcase
	end

	// Registered read answer one clock after the request
	always_ff @(posedge clk) begin
		if (rst) begin
			reg_rdata  <= mcrb_pkg::BYTE_ZERO;
			reg_rvalid <= 1'b0;
		end else begin
			reg_rvalid <= reg_rd;
			if (reg_rd) begin
				reg_rdata <= next_rdata;
			end
		end
	end

endmodule

/* File: verif/mcrb_register_bank_asserts.sv */
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Port timing checker for the register bank
// ----------------------------------------------------------------
module mcrb_register_bank_asserts (
	// Clock and reset
	input wire logic        clk,
	input wire logic        rst,
	// Byte register port
	input wire logic [8:0]  reg_addr,
	input wire logic        reg_wr,
	input wire logic        reg_rd,
	input wire logic [7:0]  reg_wdata,
	input wire logic [7:0]  reg_rdata,
	input wire logic        reg_rvalid,
	// Engine timing and region state
	input wire logic        line_cycle_end,
	input wire logic        auto_region_high,
	input wire logic        region_high,
	input wire logic        cal_mode_on,
	input wire logic        force_region,
	input wire logic        first_cycle_after_region_change,
	// Current gain sets and copy
	input wire logic [15:0] current_scale_low_set,
	input wire logic [15:0] current_scale_high_set,
	input wire logic [15:0] current_scale_in_use
);
	logic       ctl_wr;
	logic [7:0] wdata_q;
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	assign ctl_wr = reg_wr && reg_addr == mcrb_pkg::ADDR_CAL_CONTROL;
	// Last write byte, for checking what the control bits took
	always_ff @(posedge clk) begin
		wdata_q <= reg_wdata;
	end
	property p_rv; reg_rd |=> reg_rvalid; endproperty
	a_rv: assert property (p_rv) else $error("read not answered");
	property p_ctl; reg_rd && reg_addr == mcrb_pkg::ADDR_CAL_CONTROL |=> reg_rdata[7:5] == 3'h0 && !reg_rdata[1]; endproperty
	a_ctl: assert property (p_ctl) else $error("unused control bits set");
	property p_cal; ctl_wr |=> cal_mode_on == wdata_q[0]; endproperty
	a_cal: assert property (p_cal) else $error("cal mode bit not taken");
	property p_force; ctl_wr |=> force_region == wdata_q[2]; endproperty
	a_force: assert property (p_force) else $error("force bit not taken");
	property p_auto; line_cycle_end && !force_region && !reg_wr |=> region_high == $past(auto_region_high); endproperty
	a_auto: assert property (p_auto) else $error("automatic region not followed");
	property p_hold; !line_cycle_end |=> $stable(region_high); endproperty
	a_hold: assert property (p_hold) else $error("region moved between line cycles");
	property p_flag; $changed(region_high) |-> first_cycle_after_region_change == $past(cal_mode_on); endproperty
	a_flag: assert property (p_flag) else $error("first cycle flag wrong");
	property p_copy; 1'b1 |=> current_scale_in_use == ($past(region_high) ? $past(current_scale_high_set) : $past(current_scale_low_set)); endproperty
	a_copy: assert property (p_copy) else $error("current gain copy wrong");
endmodule
bind mcrb_register_bank mcrb_register_bank_asserts u_chk (.clk, .rst, .reg_addr, .reg_wr, .reg_rd, .reg_wdata,
	.reg_rdata, .reg_rvalid, .line_cycle_end, .auto_region_high, .region_high, .cal_mode_on, .force_region,
	.first_cycle_after_region_change, .current_scale_low_set, .current_scale_high_set, .current_scale_in_use);

/* File: verif/mcrb_engine_model.sv */
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Metering engine stand-in: free running line cycle boundaries
// ----------------------------------------------------------------
module mcrb_engine_model #(parameter int PERIOD = 16) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Engine timing
	output logic     line_cycle_end
);
	int cnt;
	// One clock pulse every PERIOD clocks
	always_ff @(posedge clk) begin
		if (rst) begin
			cnt <= 0;
			line_cycle_end <= 1'b0;
		end else begin
			cnt <= (cnt == PERIOD - 1) ? 0 : cnt + 1;
			line_cycle_end <= (cnt == PERIOD - 1);
		end
	end
endmodule

/* File: verif/tb_meter_calibration_register_bank.sv */
`timescale 1ns/1ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin mismatches++; $display("mismatch t=%0t got=%h exp=%h", $time, g, e); end end
module tb_meter_calibration_register_bank;
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic [8:0]  reg_addr = 9'h000;
	logic        reg_wr = 1'b0, reg_rd = 1'b0, auto_region_high = 1'b0;
	logic [7:0]  reg_wdata = 8'h00, reg_rdata, phase_delay_low_set, phase_delay_high_set, phase_delay_in_use;
	logic        reg_rvalid, line_cycle_end, region_high, cal_mode_on, force_region, first_cycle_after_region_change;
	logic [15:0] raw_current_rms, current_rms, raw_voltage_rms, voltage_rms, line_frequency, load_cos_phi;
	logic [31:0] active_power, reactive_power, apparent_power;
	logic [15:0] current_scale_low_set, current_scale_high_set, active_scale_low_set, active_scale_high_set;
	logic [15:0] reactive_scale_low_set, reactive_scale_high_set, active_pulse_scale_low_set, active_pulse_scale_high_set;
	logic [15:0] current_scale_in_use, active_scale_in_use, reactive_scale_in_use, active_pulse_scale_in_use;
	int          mismatches = 0, compares = 0;
	// Every byte holds its own address masked with a key
	function automatic logic [15:0] w(input logic [7:0] a, input logic [7:0] k);
		return {a + 8'h01, a} ^ {k, k};
	endfunction
	assign raw_current_rms = w(8'h03, 8'ha5);
	assign current_rms = w(8'h05, 8'ha5);
	assign raw_voltage_rms = w(8'h07, 8'ha5);
	assign voltage_rms = w(8'h09, 8'ha5);
	assign line_frequency = w(8'h0b, 8'ha5);
	assign active_power = {w(8'h0f, 8'ha5), w(8'h0d, 8'ha5)};
	assign reactive_power = {w(8'h13, 8'ha5), w(8'h11, 8'ha5)};
	assign apparent_power = {w(8'h17, 8'ha5), w(8'h15, 8'ha5)};
	assign load_cos_phi = w(8'h19, 8'ha5);
	assign phase_delay_low_set = 8'h1b ^ 8'h3c;
	assign phase_delay_high_set = 8'h1b ^ 8'hc3;
	assign current_scale_low_set = w(8'h1c, 8'h3c);
	assign current_scale_high_set = w(8'h1c, 8'hc3);
	assign active_scale_low_set = w(8'h1e, 8'h3c);
	assign active_scale_high_set = w(8'h1e, 8'hc3);
	assign reactive_scale_low_set = w(8'h20, 8'h3c);
	assign reactive_scale_high_set = w(8'h20, 8'hc3);
	assign active_pulse_scale_low_set = w(8'h22, 8'h3c);
	assign active_pulse_scale_high_set = w(8'h22, 8'hc3);
	// 50 MHz clock
	always #10 clk = ~clk;
	mcrb_register_bank uut (.clk, .rst, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata, .reg_rvalid,
		.line_cycle_end, .auto_region_high, .raw_current_rms, .current_rms, .raw_voltage_rms, .voltage_rms,
		.line_frequency, .active_power, .reactive_power, .apparent_power, .load_cos_phi, .phase_delay_low_set,
		.phase_delay_high_set, .current_scale_low_set, .current_scale_high_set, .active_scale_low_set,
		.active_scale_high_set, .reactive_scale_low_set, .reactive_scale_high_set, .active_pulse_scale_low_set,
		.active_pulse_scale_high_set, .region_high, .cal_mode_on, .force_region, .first_cycle_after_region_change,
		.phase_delay_in_use, .current_scale_in_use, .active_scale_in_use, .reactive_scale_in_use,
		.active_pulse_scale_in_use);
	mcrb_engine_model eng (.clk, .rst, .line_cycle_end);
	// Byte read with bounded wait on the valid pulse, then compare
	task automatic rd_chk(input logic [8:0] a, input logic [7:0] e);
		int n;
		n = 0;
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1;
		while (reg_rvalid !== 1'b1 && n < 4) begin
			@(posedge clk);
			#1;
			n++;
		end
		`CHK(reg_rdata, e)
	endtask
	// Byte write, one clock strobe
	task automatic wr(input logic [8:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask
	// Wait until a line cycle boundary has been taken
	task automatic lc;
		@(posedge line_cycle_end);
		repeat (3) @(posedge clk);
	endtask
	// Read every result and working copy byte
	task automatic scan(input logic h);
		for (int a = 3; a < 'h24; a++) rd_chk(9'(a), 8'(a) ^ (a < 'h1b ? 8'ha5 : (h ? 8'hc3 : 8'h3c)));
	endtask
	task automatic summarize;
		$display("compares=%0d mismatches=%0d", compares, mismatches);
		if (mismatches == 0 && compares > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	// Main sequence
	initial begin
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		rd_chk(9'h002, 8'h00);
		rd_chk(9'h001, 8'h00);
		rd_chk(9'h000, 8'h00);
		rd_chk(9'h024, 8'h00);
		rd_chk(9'h102, 8'h00);
		scan(1'b0);
		wr(9'h005, 8'hff);
		wr(9'h001, 8'hff);
		rd_chk(9'h005, 8'h05 ^ 8'ha5);
		rd_chk(9'h001, 8'h00);
		wr(9'h002, 8'hff);
		rd_chk(9'h002, 8'h0d);
		wr(9'h002, 8'h05);
		lc;
		rd_chk(9'h002, 8'h15);
		rd_chk(9'h001, 8'h01);
		scan(1'b1);
		lc;
		rd_chk(9'h002, 8'h05);
		wr(9'h002, 8'h01);
		lc;
		rd_chk(9'h002, 8'h11);
		rd_chk(9'h001, 8'h00);
		@(posedge clk);
		auto_region_high <= 1'b1;
		wr(9'h002, 8'h08);
		lc;
		rd_chk(9'h002, 8'h08);
		rd_chk(9'h001, 8'h01);
		summarize;
	end
	// Watchdog
	initial begin
		#100000;
		mismatches++;
		summarize;
	end
endmodule
